// ### inc/rx_sync_cfg.svh
// register map, field positions, reset values and codes for the receive timing block
`ifndef RX_SYNC_CFG_SVH
`define RX_SYNC_CFG_SVH

// register addresses (7-bit)
`define ADDR_RF_MAIN_CONTROL 7'h00
`define ADDR_MODULATION_FILTER_CONTROL 7'h01
`define ADDR_PUMP_BYPASS_OUTPUT_SELECT 7'h02
`define ADDR_CLOCK_SELECT_HIGH 7'h06
`define ADDR_CLOCK_DIVIDER_SELECT 7'h07
`define ADDR_FREQ_ERROR_CONTROL 7'h15
`define ADDR_FREQ_ERROR_RESULT 7'h16

// register reset values
`define RST_RF_MAIN_CONTROL 8'h00
`define RST_MODULATION_FILTER_CONTROL 8'h00
`define RST_PUMP_BYPASS_OUTPUT_SELECT 8'h00
`define RST_CLOCK_SELECT_HIGH 8'h00
`define RST_CLOCK_DIVIDER_SELECT 8'h01
`define RST_FREQ_ERROR_CONTROL 8'h00

// rf_main_control fields
`define POS_SYNC_EN 3
`define POS_MODE_LO 1
`define POS_MODE_HI 2
`define MODE_RECEIVE 2'h1

// clock_select_high / clock_divider_select fields
`define POS_SYNC_SEL_LO 1
`define POS_SYNC_SEL_HI 3
`define POS_REF_DIV_LO 0
`define POS_REF_DIV_HI 5

// freq_error_control fields
`define POS_EST_MODE_LO 0
`define POS_EST_MODE_HI 1
`define POS_EST_LEN_LO 2
`define POS_EST_LEN_HI 3
`define EST_MODE_OFF 2'h0
`define EST_MODE_UPDN 2'h3
`define EST_BASE_SYMBOLS 7'h08

// bit synchronizer timing, in synchronizer clock ticks per bit
`define SYNC_TICKS_PER_BIT 16
`define SYNC_SAMPLE_PHASE 4'h8
`define SYNC_LOCK_WINDOW 4'h1

`endif

// ### inc/rx_sync_pkg.sv
// types shared by the receive timing block
package rx_sync_pkg;

  typedef enum logic [2:0] {
    EST_IDLE = 3'b001,
    EST_COUNT = 3'b010,
    EST_DONE = 3'b100
  } est_state_t;

  typedef enum logic [2:0] {
    SYNC_OFF = 3'b001,
    SYNC_HUNT = 3'b010,
    SYNC_LOCK = 3'b100
  } sync_state_t;

  typedef struct packed {
    logic [1:0] len;
    logic [1:0] mode;
  } est_ctrl_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ### hdl/clock_divider.sv
// reference divider followed by a power-of-two stage, one tick per output period
`timescale 1ns/1ps
`default_nettype none

module clock_divider (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // settings
  input wire logic [5:0] i_ref_div,
  input wire logic [2:0] i_sel,
  // output tick
  output logic o_tick
);

  logic [5:0] pre_cnt;
  logic [6:0] post_cnt;
  logic ref_tick;
  logic [5:0] pre_limit;
  logic [6:0] post_limit;

  // a divider of zero is not legal; treat it as one rather than stall
  assign pre_limit = (i_ref_div == 6'h00) ? 6'h00 : i_ref_div - 6'h01;
  assign post_limit = 7'h7f >> i_sel;
  assign ref_tick = (pre_cnt >= pre_limit);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt <= 6'h00;
    end else if (ref_tick) begin
      pre_cnt <= 6'h00;
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      post_cnt <= 7'h00;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (ref_tick) begin
        if (post_cnt >= post_limit) begin
          post_cnt <= 7'h00;
          o_tick <= 1'b1;
        end else begin
          post_cnt <= post_cnt + 7'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### hdl/rx_freq_sync_top.sv
// receive frequency error estimator and bit synchronizer with control registers
`timescale 1ns/1ps
`default_nettype none
`include "rx_sync_cfg.svh"

module rx_freq_sync_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port, already deserialised by the programming interface
  input wire rx_sync_pkg::reg_req_t i_reg_req,
  input wire logic [6:0] i_reg_rd_addr,
  input wire logic i_reg_load,
  output logic [7:0] o_reg_rdata,
  // demodulator, asynchronous to i_clk
  input wire logic i_demod_data,
  input wire logic i_demod_update,
  // data interface pins
  output logic o_data_clk,
  output logic o_data_io_out,
  output logic o_data_io_oe,
  // status
  output logic o_sync_locked
);
  import rx_sync_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [7:0] rf_main_control;
  logic [7:0] modulation_filter_control;
  logic [7:0] pump_bypass_output_select;
  logic [7:0] clock_select_high;
  logic [7:0] clock_divider_select;
  logic [7:0] freq_error_control;
  logic [7:0] freq_error_result;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rf_main_control <= `RST_RF_MAIN_CONTROL;
      modulation_filter_control <= `RST_MODULATION_FILTER_CONTROL;
      pump_bypass_output_select <= `RST_PUMP_BYPASS_OUTPUT_SELECT;
      clock_select_high <= `RST_CLOCK_SELECT_HIGH;
      clock_divider_select <= `RST_CLOCK_DIVIDER_SELECT;
      freq_error_control <= `RST_FREQ_ERROR_CONTROL;
    end else if (i_reg_req.we) begin
      unique case (i_reg_req.addr)
        `ADDR_RF_MAIN_CONTROL: begin
          rf_main_control <= i_reg_req.wdata;
        end
        `ADDR_MODULATION_FILTER_CONTROL: begin
          modulation_filter_control <= i_reg_req.wdata;
        end
        `ADDR_PUMP_BYPASS_OUTPUT_SELECT: begin
          pump_bypass_output_select <= i_reg_req.wdata;
        end
        `ADDR_CLOCK_SELECT_HIGH: begin
          clock_select_high <= i_reg_req.wdata;
        end
        `ADDR_CLOCK_DIVIDER_SELECT: begin
          clock_divider_select <= i_reg_req.wdata;
        end
        `ADDR_FREQ_ERROR_CONTROL: begin
          // upper nibble is unused and reads back zero
          freq_error_control <= {4'h0, i_reg_req.wdata[3:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      unique case (i_reg_rd_addr)
        `ADDR_RF_MAIN_CONTROL: o_reg_rdata <= rf_main_control;
        `ADDR_MODULATION_FILTER_CONTROL: o_reg_rdata <= modulation_filter_control;
        `ADDR_PUMP_BYPASS_OUTPUT_SELECT: o_reg_rdata <= pump_bypass_output_select;
        `ADDR_CLOCK_SELECT_HIGH: o_reg_rdata <= clock_select_high;
        `ADDR_CLOCK_DIVIDER_SELECT: o_reg_rdata <= clock_divider_select;
        `ADDR_FREQ_ERROR_CONTROL: o_reg_rdata <= freq_error_control;
        `ADDR_FREQ_ERROR_RESULT: o_reg_rdata <= freq_error_result;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded fields

  logic rx_mode;
  logic sync_en;
  logic [5:0] ref_div;
  logic [2:0] sync_sel;
  est_ctrl_t est_ctrl;

  assign rx_mode = (rf_main_control[`POS_MODE_HI:`POS_MODE_LO] == `MODE_RECEIVE);
  assign sync_en = rf_main_control[`POS_SYNC_EN];
  assign ref_div = clock_divider_select[`POS_REF_DIV_HI:`POS_REF_DIV_LO];
  assign sync_sel = clock_select_high[`POS_SYNC_SEL_HI:`POS_SYNC_SEL_LO];
  assign est_ctrl = est_ctrl_t'(freq_error_control[3:0]);

  ////////////////////////////////////////////////////////////////////////////
  // synchronizer clock

  logic sync_tick;

  // the modulator and bit rate dividers elsewhere read the same ref_div
  clock_divider u_sync_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ref_div(ref_div),
    .i_sel(sync_sel),
    .o_tick(sync_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // demodulator inputs: two-flop synchronisers

  logic [1:0] data_meta;
  logic [1:0] upd_meta;
  logic upd_prev;
  logic demod_bit;
  logic upd_edge;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_meta <= 2'b00;
      upd_meta <= 2'b00;
      upd_prev <= 1'b0;
    end else begin
      data_meta <= {data_meta[0], i_demod_data};
      upd_meta <= {upd_meta[0], i_demod_update};
      upd_prev <= upd_meta[1];
    end
  end

  assign demod_bit = data_meta[1];
  assign upd_edge = upd_meta[1] & ~upd_prev;

  // each bit update becomes an up pulse for a one or a down pulse for a zero
  logic up_pulse;
  logic down_pulse;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      up_pulse <= 1'b0;
      down_pulse <= 1'b0;
    end else begin
      up_pulse <= upd_edge & demod_bit;
      down_pulse <= upd_edge & ~demod_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit synchronizer: 16 phases per bit, nudged by one on each data edge away from phase zero

  sync_state_t sync_state;
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic sample_prev;
  logic data_edge;
  logic sym_tick;
  logic sync_run;

  assign sync_run = rx_mode & sync_en;
  assign data_edge = sync_tick & (demod_bit != sample_prev);

  // an edge should fall on phase zero; early or late edges pull the phase
  always_comb begin
    next_phase = phase + 4'h1;
    if (data_edge && phase != 4'h0) begin
      if (phase < `SYNC_SAMPLE_PHASE) begin
        next_phase = phase;
      end else begin
        next_phase = phase + 4'h2;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase <= 4'h0;
      sample_prev <= 1'b0;
    end else if (!rx_mode) begin
      phase <= 4'h0;
      sample_prev <= demod_bit;
    end else if (sync_tick) begin
      phase <= next_phase;
      sample_prev <= demod_bit;
    end
  end

  // one symbol per bit period, at mid-bit
  assign sym_tick = rx_mode & sync_tick & (phase == `SYNC_SAMPLE_PHASE);

  // lock once an edge lands within one phase of the ideal point
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_state <= SYNC_OFF;
    end else begin
      unique case (sync_state)
        SYNC_OFF: begin
          if (sync_run) begin
            sync_state <= SYNC_HUNT;
          end
        end
        SYNC_HUNT: begin
          if (!sync_run) begin
            sync_state <= SYNC_OFF;
          end else if (data_edge && (phase <= `SYNC_LOCK_WINDOW ||
                       phase >= 4'hf)) begin
            sync_state <= SYNC_LOCK;
          end
        end
        SYNC_LOCK: begin
          if (!sync_run) begin
            sync_state <= SYNC_OFF;
          end
        end
        default: begin
          sync_state <= SYNC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sync_locked <= 1'b0;
    end else begin
      o_sync_locked <= (sync_state == SYNC_LOCK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data pins: clock rises with new data at mid-bit, falls half a bit later

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data_clk <= 1'b0;
      o_data_io_out <= 1'b0;
      o_data_io_oe <= 1'b0;
    end else begin
      // receive mode always drives the data pin; transmit leaves it released
      o_data_io_oe <= rx_mode;
      if (!sync_run) begin
        // without the synchronizer the pin follows the demodulator directly
        o_data_clk <= 1'b0;
        o_data_io_out <= demod_bit;
      end else if (sym_tick) begin
        o_data_clk <= 1'b1;
        o_data_io_out <= demod_bit;
      end else if (sync_tick && (phase == 4'h0 || (phase == 4'hf && next_phase == 4'h1))) begin
        // an early-edge nudge steps 15 to 1 and skips zero; fall there as well
        // host captures here, mid-way through the presented bit
        o_data_clk <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency error estimator

  est_state_t est_state;
  logic [6:0] sym_count;
  logic [6:0] sym_target;
  logic est_on;

  // codes 01 and 10 are treated as off, like 00
  assign est_on = (est_ctrl.mode == `EST_MODE_UPDN);
  assign sym_target = `EST_BASE_SYMBOLS << est_ctrl.len;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      est_state <= EST_IDLE;
    end else if (i_reg_load) begin
      est_state <= EST_IDLE;
    end else begin
      unique case (est_state)
        EST_IDLE: begin
          if (est_on && rx_mode) begin
            est_state <= EST_COUNT;
          end
        end
        EST_COUNT: begin
          if (!est_on) begin
            est_state <= EST_IDLE;
          end else if (sym_tick && sym_count + 7'h01 >= sym_target) begin
            est_state <= EST_DONE;
          end
        end
        EST_DONE: begin
          est_state <= EST_DONE;
        end
        default: begin
          est_state <= EST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sym_count <= 7'h00;
    end else if (i_reg_load || est_state != EST_COUNT) begin
      sym_count <= 7'h00;
    end else if (sym_tick) begin
      sym_count <= sym_count + 7'h01;
    end
  end

  // plain 8-bit add: wraps past +127 into the negative codes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      freq_error_result <= 8'h00;
    end else if (i_reg_load) begin
      freq_error_result <= 8'h00;
    end else if (est_state == EST_COUNT) begin
      if (up_pulse) begin
        freq_error_result <= freq_error_result + 8'h01;
      end else if (down_pulse) begin
        freq_error_result <= freq_error_result - 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ### dv/rx_freq_sync_checker.sv
// port-level assertion checker for the receive timing block
`timescale 1ns/1ps
`default_nettype none
`include "rx_sync_cfg.svh"

module rx_freq_sync_checker
  import rx_sync_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire rx_sync_pkg::reg_req_t i_reg_req,
  input wire logic [6:0] i_reg_rd_addr,
  input wire logic i_reg_load,
  input wire logic [7:0] o_reg_rdata,
  // data pins
  input wire logic o_data_clk,
  input wire logic o_data_io_out,
  input wire logic o_data_io_oe
);
  logic [7:0] main_q;
  logic [1:0] mode_q;
  logic [2:0] load_hist;
  logic [7:0] rdata_prev;
  logic [7:0] step;
  logic rx_on;
  logic sync_on;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // shadows of the control bits, rebuilt from observed writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      main_q <= `RST_RF_MAIN_CONTROL;
    end else if (i_reg_req.we && i_reg_req.addr == `ADDR_RF_MAIN_CONTROL) begin
      main_q <= i_reg_req.wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= 2'h0;
    end else if (i_reg_req.we && i_reg_req.addr == `ADDR_FREQ_ERROR_CONTROL) begin
      mode_q <= i_reg_req.wdata[1:0];
    end
  end

  // a load reaches the read data up to three edges later
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      load_hist <= 3'h0;
      rdata_prev <= 8'h00;
    end else begin
      load_hist <= {load_hist[1:0], i_reg_load};
      rdata_prev <= o_reg_rdata;
    end
  end

  assign rx_on = main_q[`POS_MODE_HI:`POS_MODE_LO] == `MODE_RECEIVE;
  assign sync_on = rx_on && main_q[`POS_SYNC_EN];
  assign mapped = i_reg_rd_addr inside {7'h00, 7'h01, 7'h02, 7'h06, 7'h07, 7'h15, 7'h16};
  assign step = o_reg_rdata - rdata_prev;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_load_read;
    i_reg_load && i_reg_rd_addr == 7'h16 ##1 i_reg_rd_addr == 7'h16;
  endsequence

  a_rdata_main: assert property (
    $past(i_reg_rd_addr) == 7'h00 |-> o_reg_rdata == $past(main_q))
    else $error("main control readback wrong");
  a_unmapped_zero: assert property (
    !$past(mapped) |-> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_nibble: assert property (
    $past(i_reg_rd_addr) == 7'h15 |-> o_reg_rdata[7:4] == 4'h0)
    else $error("estimator control upper bits set");
  a_load_clears: assert property (
    s_load_read |=> o_reg_rdata == 8'h00)
    else $error("result not cleared by load");
  a_result_step: assert property (
    $past(i_reg_rd_addr) == 7'h16 && $past(i_reg_rd_addr, 2) == 7'h16 && load_hist == 3'h0
    |-> step inside {8'h00, 8'h01, 8'hff})
    else $error("result moved by more than one");
  a_off_holds: assert property (
    $past(i_reg_rd_addr) == 7'h16 && $past(i_reg_rd_addr, 2) == 7'h16 && load_hist == 3'h0
    && $past(mode_q, 2) != 2'h3 && $past(mode_q, 3) != 2'h3 |-> step == 8'h00)
    else $error("result moved while estimator off");
  a_clk_off_idle: assert property (
    !sync_on [*2] |-> !o_data_clk)
    else $error("data clock running outside synchronous receive");
  a_oe_rx: assert property (
    $stable(rx_on) |-> o_data_io_oe == rx_on)
    else $error("data pin enable does not follow receive mode");
  a_data_on_rise: assert property (
    sync_on && $past(sync_on) && $past(sync_on, 2) && $changed(o_data_io_out)
    |-> $rose(o_data_clk))
    else $error("data changed away from data clock rise");
endmodule
`default_nettype wire

// ### dv/host_rx_model.sv
// host controller model sampling received bits and timing the data clock
`timescale 1ns/1ps
`default_nettype none

module host_rx_model (
  // reference clock and reset, for measuring only
  input wire logic i_clk,
  input wire logic i_rst,
  // data interface pins
  input wire logic i_data_clk,
  input wire logic i_data_pin,
  // captured bit and data clock timing in reference cycles
  output logic o_bit,
  output logic [15:0] o_period,
  output logic [15:0] o_high
);
  logic clk_q;
  logic [15:0] cnt;

  // half a bit after the device presents it, so the bit is settled
  always_ff @(negedge i_data_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bit <= 1'b0;
    end else begin
      o_bit <= i_data_pin;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_q <= 1'b0;
      cnt <= 16'h0000;
      o_period <= 16'h0000;
      o_high <= 16'h0000;
    end else begin
      clk_q <= i_data_clk;
      cnt <= (i_data_clk && !clk_q) ? 16'h0001 : cnt + 16'h0001;
      if (i_data_clk && !clk_q) begin
        o_period <= cnt;
      end
      if (!i_data_clk && clk_q) begin
        o_high <= cnt;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the receive estimator and bit synchronizer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rx_sync_pkg::*;
  logic i_clk, i_rst, i_reg_load, i_demod_data, i_demod_update;
  reg_req_t i_reg_req;
  logic [6:0] i_reg_rd_addr;
  logic [7:0] o_reg_rdata;
  logic o_data_clk, o_data_io_out, o_data_io_oe, o_sync_locked, data_pin, host_bit;
  logic [15:0] host_period, host_high;
  int n_mismatch, n_compared;
  logic [6:0] regs [6] = '{7'h00, 7'h01, 7'h02, 7'h06, 7'h07, 7'h15};
  logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] r6 [4] = '{8'h0E, 8'h0C, 8'h0E, 8'h0A};
  logic [7:0] r7 [4] = '{8'hC1, 8'hC1, 8'hC2, 8'hC3};
  logic [15:0] per [4] = '{16'h0010, 16'h0020, 16'h0020, 16'h00C0};

  rx_freq_sync_top u_dut (.i_clk, .i_rst, .i_reg_req, .i_reg_rd_addr, .i_reg_load,
    .o_reg_rdata, .i_demod_data, .i_demod_update, .o_data_clk, .o_data_io_out,
    .o_data_io_oe, .o_sync_locked);
  // released pin shows the inverse so a stale value cannot pass
  assign data_pin = o_data_io_oe ? o_data_io_out : !o_data_io_out;
  host_rx_model u_host (.i_clk, .i_rst, .i_data_clk(o_data_clk), .i_data_pin(data_pin),
    .o_bit(host_bit), .o_period(host_period), .o_high(host_high));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_reg_req = '{we: 1'b1, addr: a, wdata: d};
    cyc(1);
    i_reg_req.we = 1'b0;
    cyc(1);
  endtask

  // long wait lets a pending estimator pulse land first
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    i_reg_rd_addr = a;
    cyc(6);
    chk(o_reg_rdata, e);
  endtask

  task automatic pulse(input logic b);
    i_demod_data = b;
    cyc(1);
    i_demod_update = 1'b1;
    cyc(2);
    i_demod_update = 1'b0;
    cyc(2);
  endtask

  task automatic load();
    i_reg_rd_addr = 7'h16;
    i_reg_load = 1'b1;
    cyc(1);
    i_reg_load = 1'b0;
    cyc(3);
  endtask

  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    n_mismatch++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst = 1'b1;
    i_reg_req = '0;
    i_reg_rd_addr = 7'h00;
    i_reg_load = 1'b0;
    i_demod_data = 1'b0;
    i_demod_update = 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(regs[i], rstv[i]);
      wr(regs[i], 8'hA5);
      rd(regs[i], (i == 5) ? 8'h05 : 8'hA5);
    end
    rd(7'h10, 8'h00);
    wr(7'h16, 8'h55);
    rd(7'h16, 8'h00);
    $display("test registers done");
    wr(7'h00, 8'h0A);
    wr(7'h06, 8'h0E);
    wr(7'h07, 8'hC1);
    for (int m = 0; m < 3; m++) begin
      wr(7'h15, 8'(m));
      load();
      repeat (3) pulse(1'b1);
      rd(7'h16, 8'h00);
    end
    wr(7'h15, 8'h03);
    load();
    repeat (2) pulse(1'b1);
    repeat (5) pulse(1'b0);
    rd(7'h16, 8'hFD);
    wr(7'h15, 8'h0F);
    load();
    repeat (130) pulse(1'b1);
    rd(7'h16, 8'h82);
    $display("test estimator counting done");
    for (int l = 0; l < 4; l++) begin
      wr(7'h15, 8'(l * 4 + 3));
      load();
      cyc((8 << l) * 16 - 48);
      pulse(1'b1);
      rd(7'h16, 8'h01);
      cyc(96);
      pulse(1'b1);
      rd(7'h16, 8'h01);
    end
    $display("test estimator length done");
    wr(7'h00, 8'h02);
    cyc(40);
    chk(o_data_clk, 1'b0);
    chk(o_data_io_oe, 1'b1);
    wr(7'h00, 8'h08);
    cyc(40);
    chk(o_data_clk, 1'b0);
    chk(o_data_io_oe, 1'b0);
    $display("test synchronizer off done");
    wr(7'h00, 8'h0A);
    for (int i = 0; i < 22; i++) begin
      pulse(i[0]);
      cyc(11);
    end
    chk(o_sync_locked, 1'b1);
    i_demod_data = 1'b1;
    cyc(80);
    chk(host_bit, 1'b1);
    i_demod_data = 1'b0;
    cyc(80);
    chk(host_bit, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(7'h06, r6[i]);
      wr(7'h07, r7[i]);
      cyc(4 * per[i]);
      chk(host_period, per[i]);
      chk(host_high, per[i] / 2);
    end
    $display("test data link done");
    close_out();
  end
endmodule

bind rx_freq_sync_top rx_freq_sync_checker u_chk (.i_clk, .i_rst, .i_reg_req, .i_reg_rd_addr,
  .i_reg_load, .o_reg_rdata, .o_data_clk, .o_data_io_out, .o_data_io_oe);
`default_nettype wire
